//--- tcu_pkg.sv
// constants for the 8-bit timer/counter compare unit
`default_nettype none

package tcu_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
    localparam logic [7:0] ADDR_COUNT    = 8'h08;
    localparam logic [7:0] ADDR_CMP_A    = 8'h0c;
    localparam logic [7:0] ADDR_CMP_B    = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h14;
    localparam logic [7:0] ADDR_FLAGS    = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ACK  = 8'h1c;
    localparam logic [7:0] ADDR_PORT     = 8'h20;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_A_OMA_LSB = 6;   // output mode bits a [7:6]
    localparam int CTRL_A_OMB_LSB = 4;   // output mode bits b [5:4]
    localparam int CTRL_A_WM_LSB  = 0;   // waveform mode bits 1:0
    localparam int CTRL_B_FOA     = 7;   // force strobe a
    localparam int CTRL_B_FOB     = 6;   // force strobe b
    localparam int CTRL_B_WM2     = 3;   // waveform mode bit 2
    localparam int CTRL_B_CS_LSB  = 0;   // clock source select [2:0]
    localparam int FLAG_MA        = 0;
    localparam int FLAG_MB        = 1;
    localparam int FLAG_OV        = 2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ****************************************
    // prescaler taps
    // ****************************************
    localparam int PRESC_W   = 10;
    localparam int DIV8_M    = 8 - 1;
    localparam int DIV64_M   = 64 - 1;
    localparam int DIV256_M  = 256 - 1;
    localparam int DIV1024_M = 1024 - 1;

    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOT = 8'h00;

endpackage : tcu_pkg

`default_nettype wire

//--- tcu_top.sv
// timer/counter core with two compare channels behind an apb slave
`default_nettype none

module tcu_top (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_pin,
    output logic             irq_match_a,
    output logic             irq_match_b,
    output logic             irq_overflow,
    output logic             pin_a,
    output logic             pin_a_oe,
    output logic             pin_b,
    output logic             pin_b_oe
);

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] control_reg_a;
    logic [7:0] control_reg_b;
    logic [7:0] count_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [2:0] irq_en;
    logic       match_flag_a;
    logic       match_flag_b;
    logic       overflow_flag;
    logic [3:0] port_reg;           // [0] data a, [1] dir a, [2] data b, [3] dir b
    logic       channel_output_a;
    logic       channel_output_b;
    logic       block_match;
    localparam int PRESC_W_L = tcu_pkg::PRESC_W;
    logic [PRESC_W_L-1:0] presc;
    logic       ext_s1, ext_s2, ext_s3;

    // ****************************************
    // decode
    // ****************************************
    logic       wr;
    logic [2:0] waveform_mode_field;
    logic [2:0] clock_source_select;
    logic [1:0] om_a, om_b;
    logic       pwm_mode, top_is_cmp, top, bottom, timer_tick;
    logic       up_dir;
    logic [7:0] top_val;
    logic       match_a, match_b;

    assign wr     = psel && penable && pwrite;
    assign waveform_mode_field = {control_reg_b[tcu_pkg::CTRL_B_WM2],
                                  control_reg_a[tcu_pkg::CTRL_A_WM_LSB +: 2]};
    assign clock_source_select = control_reg_b[tcu_pkg::CTRL_B_CS_LSB +: 3];
    assign om_a = control_reg_a[tcu_pkg::CTRL_A_OMA_LSB +: 2];
    assign om_b = control_reg_a[tcu_pkg::CTRL_A_OMB_LSB +: 2];
    // modes 1,3,5,7 are pwm
    assign pwm_mode   = waveform_mode_field[0];
    assign top_is_cmp = waveform_mode_field[2] || (waveform_mode_field == 3'd2);
    assign top_val    = top_is_cmp ? compare_value_a : tcu_pkg::COUNT_MAX;
    assign top    = (count_value == top_val);
    assign bottom = (count_value == tcu_pkg::COUNT_BOT);
    assign match_a = (count_value == compare_value_a);
    assign match_b = (count_value == compare_value_b);

    // ****************************************
    // clock select and prescaler
    // ****************************************
    // free-running prescaler, independent of clock select
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end

    // pin synchroniser; s1 only feeds s2
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= external_count_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // tick enable selection
    always_comb begin
        case (clock_source_select)
            3'd0: timer_tick = 1'b0;
            3'd1: timer_tick = 1'b1;
            3'd2: timer_tick = (presc[2:0] == 3'(tcu_pkg::DIV8_M));
            3'd3: timer_tick = (presc[5:0] == 6'(tcu_pkg::DIV64_M));
            3'd4: timer_tick = (presc[7:0] == 8'(tcu_pkg::DIV256_M));
            3'd5: timer_tick = (presc == PRESC_W_L'(tcu_pkg::DIV1024_M));
            3'd6: timer_tick = ext_s3 && !ext_s2;
            3'd7: timer_tick = !ext_s3 && ext_s2;
            default: timer_tick = 1'b0;
        endcase
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            control_reg_a <= tcu_pkg::RST_BYTE;
            control_reg_b <= tcu_pkg::RST_BYTE;
            irq_en        <= 3'h0;
            port_reg      <= 4'h0;
        end else if (wr) begin
            if (paddr == tcu_pkg::ADDR_CTRL_A) control_reg_a <= pwdata[7:0];
            // force strobes are not stored
            if (paddr == tcu_pkg::ADDR_CTRL_B) control_reg_b <= {2'b00, pwdata[5:0]};
            if (paddr == tcu_pkg::ADDR_IRQ_EN) irq_en <= pwdata[2:0];
            if (paddr == tcu_pkg::ADDR_PORT)   port_reg <= pwdata[3:0];
        end
    end

    // ****************************************
    // counter
    // ****************************************
    // direction state only matters in dual-slope modes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            up_dir <= 1'b1;
        end else if (timer_tick && pwm_mode && !waveform_mode_field[1]) begin
            if (top)
                up_dir <= 1'b0;
            else if (bottom)
                up_dir <= 1'b1;
        end else if (!(pwm_mode && !waveform_mode_field[1])) begin
            up_dir <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= tcu_pkg::RST_BYTE;
        end else if (wr && paddr == tcu_pkg::ADDR_COUNT) begin
            count_value <= pwdata[7:0];
        end else if (timer_tick) begin
            if (waveform_mode_field == 3'd0)
                count_value <= count_value + 8'h01;           // wraps naturally
            else if (pwm_mode && !waveform_mode_field[1]) begin
                // turn round at bottom rather than wrap to 0xff
                if (bottom || (up_dir && !top))
                    count_value <= count_value + 8'h01;
                else
                    count_value <= count_value - 8'h01;
            end else if (top)
                count_value <= tcu_pkg::COUNT_BOT;            // clear at top
            else
                count_value <= count_value + 8'h01;
        end
    end

    // a count write blocks matches until the next tick has passed, even stopped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            block_match <= 1'b0;
        end else if (wr && paddr == tcu_pkg::ADDR_COUNT) begin
            block_match <= 1'b1;
        end else if (timer_tick) begin
            block_match <= 1'b0;
        end
    end

    // ****************************************
    // compare registers with double buffer
    // ****************************************
    logic load_pt;
    assign load_pt = timer_tick &&
                     (waveform_mode_field[1] ? top : top);    // load at top
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            compare_value_a <= tcu_pkg::RST_BYTE;
            compare_value_b <= tcu_pkg::RST_BYTE;
            buf_a           <= tcu_pkg::RST_BYTE;
            buf_b           <= tcu_pkg::RST_BYTE;
        end else begin
            if (wr && paddr == tcu_pkg::ADDR_CMP_A) buf_a <= pwdata[7:0];
            if (wr && paddr == tcu_pkg::ADDR_CMP_B) buf_b <= pwdata[7:0];
            if (!pwm_mode) begin
                if (wr && paddr == tcu_pkg::ADDR_CMP_A) compare_value_a <= pwdata[7:0];
                if (wr && paddr == tcu_pkg::ADDR_CMP_B) compare_value_b <= pwdata[7:0];
            end else if (load_pt) begin
                compare_value_a <= buf_a;
                compare_value_b <= buf_b;
            end
        end
    end

    // ****************************************
    // flags
    // ****************************************
    logic fa_set, fb_set, ov_set;
    logic flag_wr, ack_wr;
    assign fa_set  = timer_tick && match_a && !block_match;
    assign fb_set  = timer_tick && match_b && !block_match;
    assign ov_set  = timer_tick && (waveform_mode_field == 3'd0) &&
                     (count_value == tcu_pkg::COUNT_MAX) && !(wr && paddr == tcu_pkg::ADDR_COUNT);
    assign flag_wr = wr && paddr == tcu_pkg::ADDR_FLAGS;
    assign ack_wr  = wr && paddr == tcu_pkg::ADDR_IRQ_ACK;

    // set wins over any clear in the same cycle; writing zero keeps a flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            match_flag_a  <= 1'b0;
            match_flag_b  <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            if (fa_set)
                match_flag_a <= 1'b1;
            else if ((flag_wr || ack_wr) && pwdata[tcu_pkg::FLAG_MA])
                match_flag_a <= 1'b0;
            if (fb_set)
                match_flag_b <= 1'b1;
            else if ((flag_wr || ack_wr) && pwdata[tcu_pkg::FLAG_MB])
                match_flag_b <= 1'b0;
            if (ov_set)
                overflow_flag <= 1'b1;
            else if ((flag_wr || ack_wr) && pwdata[tcu_pkg::FLAG_OV])
                overflow_flag <= 1'b0;
        end
    end

    // interrupt requests registered so outputs come from flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_match_a  <= 1'b0;
            irq_match_b  <= 1'b0;
            irq_overflow <= 1'b0;
        end else begin
            irq_match_a  <= match_flag_a && irq_en[tcu_pkg::FLAG_MA];
            irq_match_b  <= match_flag_b && irq_en[tcu_pkg::FLAG_MB];
            irq_overflow <= overflow_flag && irq_en[tcu_pkg::FLAG_OV];
        end
    end

    // ****************************************
    // channel outputs
    // ****************************************
    // non-pwm action: 1 toggle, 2 clear, 3 set, 0 none
    function automatic logic next_out(input logic [1:0] om, input logic cur);
        case (om)
            2'd1:    return !cur;
            2'd2:    return 1'b0;
            2'd3:    return 1'b1;
            default: return cur;
        endcase
    endfunction

    logic force_a, force_b;
    assign force_a = wr && paddr == tcu_pkg::ADDR_CTRL_B && !pwm_mode &&
                     pwdata[tcu_pkg::CTRL_B_FOA];
    assign force_b = wr && paddr == tcu_pkg::ADDR_CTRL_B && !pwm_mode &&
                     pwdata[tcu_pkg::CTRL_B_FOB];

    // registers not touched by mode writes, so they persist across mode changes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            channel_output_a <= 1'b0;
            channel_output_b <= 1'b0;
        end else begin
            if (force_a || (!pwm_mode && fa_set))
                channel_output_a <= next_out(om_a, channel_output_a);
            if (force_b || (!pwm_mode && fb_set))
                channel_output_b <= next_out(om_b, channel_output_b);
        end
    end

    // pin mux: output register overrides port data when output mode nonzero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_a    <= 1'b0;
            pin_a_oe <= 1'b0;
            pin_b    <= 1'b0;
            pin_b_oe <= 1'b0;
        end else begin
            pin_a    <= (om_a != 2'd0) ? channel_output_a : port_reg[0];
            pin_a_oe <= port_reg[1];
            pin_b    <= (om_b != 2'd0) ? channel_output_b : port_reg[2];
            pin_b_oe <= port_reg[3];
        end
    end

    // ****************************************
    // apb read side
    // ****************************************
    logic [7:0] rd_byte;
    logic       mapped;
    always_comb begin
        mapped = 1'b1;
        case (paddr)
            tcu_pkg::ADDR_CTRL_A:  rd_byte = control_reg_a;
            tcu_pkg::ADDR_CTRL_B:  rd_byte = control_reg_b;
            tcu_pkg::ADDR_COUNT:   rd_byte = count_value;
            tcu_pkg::ADDR_CMP_A:   rd_byte = pwm_mode ? buf_a : compare_value_a;
            tcu_pkg::ADDR_CMP_B:   rd_byte = pwm_mode ? buf_b : compare_value_b;
            tcu_pkg::ADDR_IRQ_EN:  rd_byte = {5'h00, irq_en};
            tcu_pkg::ADDR_FLAGS:   rd_byte = {5'h00, overflow_flag, match_flag_b, match_flag_a};
            tcu_pkg::ADDR_IRQ_ACK: rd_byte = 8'h00;
            tcu_pkg::ADDR_PORT:    rd_byte = {4'h0, port_reg};
            default: begin
                rd_byte = 8'h00;
                mapped  = 1'b0;
            end
        endcase
    end

    // zero-wait answer: pready is a flop loaded in the setup cycle, high in the access cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

endmodule : tcu_top

`default_nettype wire

//--- tcu_top_assertions.sv
// port-level checker for the timer/counter compare unit
`default_nettype none

module tcu_chk (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq_match_a,
    input wire logic        pin_a,
    input wire logic        pin_b,
    input wire logic        pin_a_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // bus timing and decode
    // ****************************************
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (psel && !penable && paddr > 8'h20 |=> pslverr)
        else $error("unmapped address not refused");
    a_mapped_no_err: assert property (psel && !penable && paddr <= 8'h20 && paddr[1:0] == 2'b00
        |=> !pslverr) else $error("mapped address refused");
    // force strobes are write-only, so they never read back
    a_force_reads_zero: assert property (psel && !penable && !pwrite
        && paddr == tcu_pkg::ADDR_CTRL_B |=> prdata[31:6] == 26'h0)
        else $error("force strobe read back");

    // ****************************************
    // outputs tied to their cause
    // ****************************************
    a_irq_disable: assert property (psel && penable && pwrite
        && paddr == tcu_pkg::ADDR_IRQ_EN && !pwdata[0] |=> ##1 !irq_match_a)
        else $error("irq a stays with enable off");
    a_dir_follows_port: assert property (psel && penable && pwrite
        && paddr == tcu_pkg::ADDR_PORT |=> ##1 pin_a_oe == $past(pwdata[1], 2))
        else $error("direction a not from port");
    a_reset_pins_low: assert property ($rose(rst_n) |-> !pin_a && !pin_b && !pready)
        else $error("outputs not cleared by reset");
endmodule // tcu_chk

bind tcu_top tcu_chk i_tcu_chk (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_match_a(irq_match_a), .pin_a(pin_a), .pin_b(pin_b),
    .pin_a_oe(pin_a_oe)
);

`default_nettype wire

//--- test_tcu_top.sv
// self-checking testbench for the timer/counter compare unit
`default_nettype none

module test_tcu_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_pin = 1'b0;
    logic        irq_a, irq_b, irq_ov, pin_a, pin_a_oe, pin_b, pin_b_oe;
    logic [31:0] rd;
    logic        rd_err;
    logic [7:0]  mdl_count;
    int          err_total = 0;
    int          checks = 0;
    int          seed = 25485;
    int          n;

    // ****************************************
    // clock and design
    // ****************************************
    always #50 mclk = ~mclk;

    tcu_top i_tcu_top (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin(ext_pin), .irq_match_a(irq_a),
        .irq_match_b(irq_b), .irq_overflow(irq_ov), .pin_a(pin_a), .pin_a_oe(pin_a_oe),
        .pin_b(pin_b), .pin_b_oe(pin_b_oe)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wait_high(ref logic s, input string what);
        n = 0;
        while (s !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        check(what, 32'(s), 32'h1);
    endtask

    task automatic complete_run;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        complete_run;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        apb(0, tcu_pkg::ADDR_COUNT, 0); check("count rst", rd, 32'h0);
        check("pin a rst", 32'(pin_a), 32'h0);
        apb(0, 8'h40, 0); check("unmapped err", 32'(rd_err), 32'h1);
        // stopped counter holds random writes
        for (int i = 0; i < 4; i++) begin
            mdl_count = 8'($random(seed));
            apb(1, tcu_pkg::ADDR_COUNT, {24'h0, mdl_count});
            apb(1, tcu_pkg::ADDR_CMP_B, {24'h0, ~mdl_count});
            repeat (20) @(posedge mclk);
            apb(0, tcu_pkg::ADDR_COUNT, 0); check("count hold", rd, {24'h0, mdl_count});
            apb(0, tcu_pkg::ADDR_CMP_B, 0); check("cmp direct", rd, {24'h0, ~mdl_count});
        end
        // external pin edges, falling then rising
        for (int cs = 6; cs < 8; cs++) begin
            apb(1, tcu_pkg::ADDR_COUNT, 0);
            apb(1, tcu_pkg::ADDR_CTRL_B, cs);
            mdl_count = 8'h00;
            repeat (5) begin
                repeat (4) @(posedge mclk);
                ext_pin <= 1'b1;
                repeat (4) @(posedge mclk);
                ext_pin <= 1'b0;
                mdl_count++;
            end
            repeat (6) @(posedge mclk);
            apb(1, tcu_pkg::ADDR_CTRL_B, 0);
            apb(0, tcu_pkg::ADDR_COUNT, 0); check("pin edges", rd, {24'h0, mdl_count});
        end
        // match a sets flag and irq
        apb(1, tcu_pkg::ADDR_FLAGS, 32'h7);
        apb(1, tcu_pkg::ADDR_CMP_A, 32'h20);
        apb(1, tcu_pkg::ADDR_CMP_B, 32'h24);
        apb(1, tcu_pkg::ADDR_IRQ_EN, 32'h3);
        apb(1, tcu_pkg::ADDR_COUNT, 32'h10);
        apb(1, tcu_pkg::ADDR_CTRL_B, 32'h1);
        wait_high(irq_a, "irq a");
        wait_high(irq_b, "irq b");
        apb(1, tcu_pkg::ADDR_CTRL_B, 0);
        apb(1, tcu_pkg::ADDR_FLAGS, 0);
        apb(0, tcu_pkg::ADDR_FLAGS, 0); check("flags kept", rd & 32'h3, 32'h3);
        apb(1, tcu_pkg::ADDR_FLAGS, 32'h1);
        apb(0, tcu_pkg::ADDR_FLAGS, 0); check("flag a clr", rd & 32'h3, 32'h2);
        // count write equal to compare: first tick's match is blocked
        apb(1, tcu_pkg::ADDR_CMP_A, 32'h30);
        apb(1, tcu_pkg::ADDR_COUNT, 32'h30);
        apb(1, tcu_pkg::ADDR_CTRL_B, 32'h1);
        apb(1, tcu_pkg::ADDR_CTRL_B, 0);
        apb(0, tcu_pkg::ADDR_FLAGS, 0); check("blocked", rd & 32'h1, 32'h0);
        // wrap in normal mode sets overflow; acknowledge clears it
        apb(1, tcu_pkg::ADDR_IRQ_EN, 32'h4);
        apb(1, tcu_pkg::ADDR_COUNT, 32'hf0);
        apb(1, tcu_pkg::ADDR_CTRL_B, 32'h1);
        wait_high(irq_ov, "irq ovf");
        apb(1, tcu_pkg::ADDR_CTRL_B, 0);
        apb(0, tcu_pkg::ADDR_COUNT, 0); check("wrapped", 32'(rd < 32'h30), 32'h1);
        apb(1, tcu_pkg::ADDR_IRQ_ACK, 32'h4);
        apb(0, tcu_pkg::ADDR_FLAGS, 0); check("ovf ack", rd & 32'h4, 32'h0);
        // force a in toggle mode and b in set mode, refused in pwm, kept across mode change
        apb(1, tcu_pkg::ADDR_FLAGS, 32'h7);
        apb(1, tcu_pkg::ADDR_PORT, 32'ha);
        apb(1, tcu_pkg::ADDR_CTRL_A, 32'h70);
        apb(1, tcu_pkg::ADDR_CTRL_B, 32'hc0);
        repeat (3) @(posedge mclk);
        check("force a", 32'(pin_a), 32'h1);
        check("force b", 32'(pin_b), 32'h1);
        check("dir a", 32'(pin_a_oe), 32'h1);
        check("dir b", 32'(pin_b_oe), 32'h1);
        apb(0, tcu_pkg::ADDR_FLAGS, 0); check("force no flag", rd & 32'h3, 32'h0);
        apb(1, tcu_pkg::ADDR_CTRL_A, 32'h71);
        apb(1, tcu_pkg::ADDR_CTRL_B, 32'hc0);
        apb(1, tcu_pkg::ADDR_CTRL_A, 32'h70);
        repeat (3) @(posedge mclk);
        check("out kept", 32'(pin_a), 32'h1);
        check("out b kept", 32'(pin_b), 32'h1);
        apb(1, tcu_pkg::ADDR_CTRL_B, 32'h80);
        repeat (3) @(posedge mclk);
        check("toggle", 32'(pin_a), 32'h0);
        check("b untouched", 32'(pin_b), 32'h1);
        // mode zero hands the pin back to port data
        apb(1, tcu_pkg::ADDR_CTRL_A, 32'h0);
        apb(1, tcu_pkg::ADDR_PORT, 32'h3);
        repeat (3) @(posedge mclk);
        check("port data", 32'(pin_a), 32'h1);
        check("port data b", 32'(pin_b), 32'h0);
        check("dir b off", 32'(pin_b_oe), 32'h0);
        complete_run;
    end
endmodule // test_tcu_top

`default_nettype wire
